/* File: hw/pcrc_pkg.sv */
// Purpose: Constants shared by the programmable CRC engine.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package pcrc_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL1     = 8'h00;
  localparam logic [7:0] OFF_CTRL2     = 8'h04;
  localparam logic [7:0] OFF_TAPS_LO   = 8'h08;
  localparam logic [7:0] OFF_TAPS_HI   = 8'h0c;
  localparam logic [7:0] OFF_IN_LO     = 8'h10;
  localparam logic [7:0] OFF_IN_HI     = 8'h14;
  localparam logic [7:0] OFF_RES_LO    = 8'h18;
  localparam logic [7:0] OFF_RES_HI    = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;
  // ==========================================================================
  // Control one field positions
  localparam int BIT_ON      = 15;
  localparam int BIT_IDLE    = 13;
  localparam int POS_COUNT   = 8;
  localparam int BIT_FULL    = 7;
  localparam int BIT_EMPTY   = 6;
  localparam int BIT_ISEL    = 5;
  localparam int BIT_RUN     = 4;
  localparam int BIT_LSB     = 3;
  // Control two field positions
  localparam int POS_DATA_WIDTH_FIELD  = 8;
  localparam int POS_POLY_LENGTH    = 0;
  // ==========================================================================
  // Sizes and reset values
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [4:0]  DEPTH_WIDE  = 5'h10;
  localparam logic [4:0]  DEPTH_NARR  = 5'h08;
  localparam logic [4:0]  POLY_LENGTH_NARROW = 5'h07;
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam logic [15:0] RST_CTRL2   = 16'h1f1f;
  // Interrupt status bits
  localparam int IRQ_EMPTY = 0;
  localparam int IRQ_DONE  = 1;
endpackage

/* File: hw/pcrc_shifter.sv */
// Purpose: One step of the programmable CRC shift register.
// Assumes: Length field holds the polynomial length minus one.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module pcrc_shifter (
  // Current state and setup
  input  wire logic [31:0] crc_in,
  input  wire logic [31:0] taps_in,
  input  wire logic [4:0]  poly_length_in,
  // Data bit
  input  wire logic        bit_in,
  // Next state
  output logic      [31:0] crc_out
);
  // ==========================================================================
  // Feedback step
  logic [31:0] mask;
  logic        fb;
  always_comb begin
    mask    = 32'hffff_ffff >> (5'd31 - poly_length_in);
    fb      = crc_in[poly_length_in] ^ bit_in;
    crc_out = ({crc_in[30:0], 1'b0} ^ (fb ? taps_in : 32'h0000_0000)) & mask;
  end
endmodule

/* File: hw/pcrc_top.sv */
// Purpose: Programmable CRC engine with input FIFO behind APB.
// Assumes: 20 MHz clock, single clock domain.
// Notes:   One data bit is shifted per clock cycle.
`timescale 1ns/1ns
module pcrc_top (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Interrupt
  output logic             irq_out
);
  typedef enum logic [1:0] {PCRC_IDLE, PCRC_SHIFT, PCRC_TAIL} pcrc_state_e;

  // ==========================================================================
  // Registers
  logic              on_q, idle_q, isel_q, run_q, lsb_q;
  logic [4:0]        data_width_field_q, poly_length_q;
  logic [31:0]       taps_q, inlo_q, res_q;
  logic [1:0]        stat_q, mask_q;
  logic [31:0]       fifo_q [pcrc_pkg::FIFO_DEPTH];
  logic [3:0]        wptr_q, rptr_q;
  logic [4:0]        count_q;
  logic [4:0]        bit_q;
  logic [4:0]        tail_q;
  logic [31:0]       word_q;
  pcrc_state_e       state_q;
  logic [31:0]       crc_next;
  logic [4:0]        limit;
  logic              wr, rd, push, pop, full, empty, done, sw_stop;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr      = psel_in && penable_in && pwrite_in;
  assign rd      = psel_in && penable_in && !pwrite_in;
  assign limit   = (poly_length_q >= pcrc_pkg::POLY_LENGTH_NARROW) ? pcrc_pkg::DEPTH_NARR : pcrc_pkg::DEPTH_WIDE;
  assign full    = (count_q >= limit);
  assign empty   = (count_q == 5'h00);
  assign push    = wr && hit(paddr_in, pcrc_pkg::OFF_IN_HI) && on_q && !full;
  assign pop     = (state_q != PCRC_SHIFT || bit_q == 5'h00) && run_q && !empty && state_q != PCRC_TAIL;
  assign sw_stop = wr && hit(paddr_in, pcrc_pkg::OFF_CTRL1) && !pwdata_in[pcrc_pkg::BIT_RUN];
  assign done    = (state_q == PCRC_TAIL) && (tail_q == 5'h00) && run_q;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      on_q     <= 1'b0;
      idle_q   <= 1'b0;
      isel_q   <= 1'b0;
      lsb_q    <= 1'b0;
      data_width_field_q <= pcrc_pkg::RST_CTRL2[12:8];
      poly_length_q   <= pcrc_pkg::RST_CTRL2[4:0];
      taps_q   <= pcrc_pkg::RST_ZERO;
      inlo_q   <= pcrc_pkg::RST_ZERO;
      mask_q   <= 2'h0;
    end else if (wr) begin
      if (hit(paddr_in, pcrc_pkg::OFF_CTRL1)) begin
        on_q   <= pwdata_in[pcrc_pkg::BIT_ON];
        idle_q <= pwdata_in[pcrc_pkg::BIT_IDLE];
        isel_q <= pwdata_in[pcrc_pkg::BIT_ISEL];
        lsb_q  <= pwdata_in[pcrc_pkg::BIT_LSB];
      end
      if (hit(paddr_in, pcrc_pkg::OFF_CTRL2)) begin
        data_width_field_q <= pwdata_in[pcrc_pkg::POS_DATA_WIDTH_FIELD +: 5];
        poly_length_q   <= pwdata_in[pcrc_pkg::POS_POLY_LENGTH +: 5];
      end
      if (hit(paddr_in, pcrc_pkg::OFF_TAPS_LO)) begin
        taps_q[15:0] <= pwdata_in[15:0];
      end
      if (hit(paddr_in, pcrc_pkg::OFF_TAPS_HI)) begin
        taps_q[31:16] <= pwdata_in[15:0];
      end
      if (hit(paddr_in, pcrc_pkg::OFF_IN_LO)) begin
        inlo_q <= {16'h0000, pwdata_in[15:0]};
      end
      if (hit(paddr_in, pcrc_pkg::OFF_IRQ_MASK)) begin
        mask_q <= pwdata_in[1:0];
      end
    end
  end

  // ==========================================================================
  // Input FIFO
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wptr_q  <= 4'h0;
      rptr_q  <= 4'h0;
      count_q <= 5'h00;
    end else if (!on_q) begin
      wptr_q  <= 4'h0;
      rptr_q  <= 4'h0;
      count_q <= 5'h00;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 4'h1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 4'h1;
      end
      if (push && !pop) begin
        count_q <= count_q + 5'h01;
      end else if (pop && !push) begin
        count_q <= count_q - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < pcrc_pkg::FIFO_DEPTH; i++) begin
        fifo_q[i] <= pcrc_pkg::RST_ZERO;
      end
    end else if (push) begin
      fifo_q[wptr_q] <= {pwdata_in[15:0], inlo_q[15:0]};
    end
  end

  // ==========================================================================
  // Shifter state machine
  pcrc_shifter u_step (
    .crc_in  (res_q),
    .taps_in (taps_q),
    .poly_length_in (poly_length_q),
    .bit_in  (lsb_q ? word_q[0] : word_q[data_width_field_q]),
    .crc_out (crc_next)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= PCRC_IDLE;
      bit_q   <= 5'h00;
      tail_q  <= 5'h00;
      word_q  <= pcrc_pkg::RST_ZERO;
    end else if (!on_q) begin
      state_q <= PCRC_IDLE;
      bit_q   <= 5'h00;
    end else begin
      case (state_q)
        PCRC_IDLE: begin
          if (pop) begin
            state_q <= PCRC_SHIFT;
            word_q  <= fifo_q[rptr_q];
            bit_q   <= data_width_field_q;
          end
        end
        PCRC_SHIFT: begin
          word_q <= lsb_q ? (word_q >> 1) : (word_q << 1);
          bit_q  <= bit_q - 5'h01;
          if (bit_q == 5'h00) begin
            if (pop) begin
              word_q <= fifo_q[rptr_q];
              bit_q  <= data_width_field_q;
            end else begin
              state_q <= PCRC_TAIL;
              tail_q  <= 5'((6'(poly_length_q) + 6'h01) >> 1);
            end
          end
        end
        PCRC_TAIL: begin
          if (!run_q) begin
            state_q <= PCRC_IDLE;
          end else if (tail_q == 5'h00) begin
            state_q <= PCRC_IDLE;
          end else begin
            tail_q <= tail_q - 5'h01;
          end
        end
        default: begin
          state_q <= PCRC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Run bit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
    end else if (!on_q) begin
      run_q <= 1'b0;
    end else if (wr && hit(paddr_in, pcrc_pkg::OFF_CTRL1)) begin
      run_q <= pwdata_in[pcrc_pkg::BIT_RUN];
    end else if (done) begin
      run_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Result register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_q <= pcrc_pkg::RST_ZERO;
    end else if (on_q) begin
      if (wr && hit(paddr_in, pcrc_pkg::OFF_RES_LO)) begin
        res_q[15:0] <= pwdata_in[15:0];
      end else if (wr && hit(paddr_in, pcrc_pkg::OFF_RES_HI)) begin
        res_q[31:16] <= pwdata_in[15:0];
      end else if (state_q == PCRC_SHIFT) begin
        res_q <= crc_next;
      end
    end
  end

  // ==========================================================================
  // Interrupt status and output
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_q  <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && hit(paddr_in, pcrc_pkg::OFF_IRQ_STAT) && pwdata_in[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (!isel_q && pop && !push && count_q == 5'h01) begin
        stat_q[pcrc_pkg::IRQ_EMPTY] <= 1'b1;
      end
      if (isel_q && done && !sw_stop) begin
        stat_q[pcrc_pkg::IRQ_DONE] <= 1'b1;
      end
      irq_out <= |(stat_q & mask_q);
    end
  end

  // ==========================================================================
  // APB read and response
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= pcrc_pkg::RST_ZERO;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      if (psel_in && !penable_in && !pwrite_in) begin
        case (paddr_in)
          pcrc_pkg::OFF_CTRL1:    prdata_out <= {16'h0000, on_q, 1'b0, idle_q, count_q, full, empty,
                                                 isel_q, run_q, lsb_q, 3'h0};
          pcrc_pkg::OFF_CTRL2:    prdata_out <= {19'h00000, data_width_field_q, 3'h0, poly_length_q};
          pcrc_pkg::OFF_TAPS_LO:  prdata_out <= {16'h0000, taps_q[15:0]};
          pcrc_pkg::OFF_TAPS_HI:  prdata_out <= {16'h0000, taps_q[31:16]};
          pcrc_pkg::OFF_RES_LO:   prdata_out <= {16'h0000, res_q[15:0]};
          pcrc_pkg::OFF_RES_HI:   prdata_out <= {16'h0000, res_q[31:16]};
          pcrc_pkg::OFF_IRQ_STAT: prdata_out <= {30'h00000000, stat_q};
          pcrc_pkg::OFF_IRQ_MASK: prdata_out <= {30'h00000000, mask_q};
          default:                prdata_out <= pcrc_pkg::RST_ZERO;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  chk_full_limit: assert property (@(posedge clk_in) disable iff (rst_in)
    count_q <= limit) else $error("fifo count above limit");
  chk_empty_irq: assert property (@(posedge clk_in) disable iff (rst_in)
    (!isel_q && pop && !push && count_q == 5'h01) |=> stat_q[pcrc_pkg::IRQ_EMPTY])
    else $error("empty interrupt missing");
  chk_done_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    (done && on_q && !wr) |=> !run_q) else $error("run bit not cleared");
  chk_off_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    !on_q |=> (count_q == 5'h00 && state_q == PCRC_IDLE)) else $error("off did not reset");
  chk_push_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (push && !pop && on_q) |=> count_q == $past(count_q) + 5'h01) else $error("push not counted");
  chk_tail_len: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PCRC_SHIFT && $past(state_q) == PCRC_SHIFT && bit_q == 5'h00 && !pop && on_q)
    |=> tail_q == 5'((6'(poly_length_q) + 6'h01) >> 1)) else $error("tail length wrong");
  chk_sw_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    (sw_stop && !done) |=> !$rose(stat_q[pcrc_pkg::IRQ_DONE]) ##1 !$rose(stat_q[pcrc_pkg::IRQ_DONE]))
    else $error("software stop raised interrupt");
  chk_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
    (isel_q && done && !sw_stop) |=> ##1 (irq_out == mask_q[pcrc_pkg::IRQ_DONE]) || !mask_q[1])
    else $error("done interrupt missing");
  chk_done_irq: assert property (@(posedge clk_in) disable iff (rst_in)
    (isel_q && done && !sw_stop) |=> stat_q[pcrc_pkg::IRQ_DONE])
    else $error("done status not set");
  chk_empty_sel: assert property (@(posedge clk_in) disable iff (rst_in)
    isel_q |=> !$rose(stat_q[pcrc_pkg::IRQ_EMPTY]))
    else $error("empty status set in done mode");
  chk_full_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr && hit(paddr_in, pcrc_pkg::OFF_IN_HI) && full && !pop && on_q) |=> count_q == $past(count_q))
    else $error("push accepted while full");
  chk_pair_push: assert property (@(posedge clk_in) disable iff (rst_in)
    push |=> fifo_q[$past(wptr_q)] == {$past(pwdata_in[15:0]), $past(inlo_q[15:0])})
    else $error("input pair stored wrongly");
  chk_off_ptrs: assert property (@(posedge clk_in) disable iff (rst_in)
    !on_q |=> (!run_q && wptr_q == 4'h0 && rptr_q == 4'h0))
    else $error("off did not clear pointers");
  chk_run_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PCRC_IDLE && run_q && !empty && on_q) |=> state_q == PCRC_SHIFT)
    else $error("run did not start shifter");
  chk_width_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PCRC_IDLE && pop && on_q) |=> bit_q == $past(data_width_field_q))
    else $error("bit count not loaded from width");
  chk_bit_order: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PCRC_SHIFT && bit_q != 5'h00 && on_q)
    |=> word_q == ($past(lsb_q) ? ($past(word_q) >> 1) : ($past(word_q) << 1)))
    else $error("input word shifted the wrong way");
  chk_tail_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PCRC_TAIL && run_q && tail_q != 5'h00 && on_q) |=> tail_q == $past(tail_q) - 5'h01)
    else $error("tail count did not step");
  chk_taps_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr && hit(paddr_in, pcrc_pkg::OFF_TAPS_LO)) |=> taps_q[15:0] == $past(pwdata_in[15:0]))
    else $error("low taps not written");
  chk_result_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr && hit(paddr_in, pcrc_pkg::OFF_RES_LO) && on_q) |=> res_q[15:0] == $past(pwdata_in[15:0]))
    else $error("result write lost");
  chk_shift_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == PCRC_SHIFT && on_q && !(wr && hit(paddr_in, pcrc_pkg::OFF_RES_LO))
     && !(wr && hit(paddr_in, pcrc_pkg::OFF_RES_HI))) |=> res_q == $past(crc_next))
    else $error("shift step not applied");
  chk_result_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (psel_in && !penable_in && !pwrite_in && hit(paddr_in, pcrc_pkg::OFF_RES_LO))
    |=> prdata_out == {16'h0000, $past(res_q[15:0])})
    else $error("result read wrong");
endmodule

/* File: verif/pcrc_top_tb.sv */
// Purpose: Self-checking bench for the programmable CRC engine.
// Assumes: APB slave answers before the watchdog expires.
// Notes:   Expected CRC values come from a bench model.
`timescale 1ns/1ns
module pcrc_top_tb;
  // ==========================================================================
  // Signals
  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [7:0]  paddr_in   = 8'h00;
  logic [31:0] pwdata_in  = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  int          error_cnt  = 0;
  int          checked    = 0;
  logic [31:0] rd;
  logic        slv_err;
  logic [31:0] exp_crc;
  logic [15:0] words [4];

  always #25 clk_in = ~clk_in;

  pcrc_top dut (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .irq_out     (irq_out)
  );

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    slv_err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic push(input logic [15:0] w);
    apb(1'b1, pcrc_pkg::OFF_IN_LO, {16'h0000, w});
    apb(1'b1, pcrc_pkg::OFF_IN_HI, 32'h0000_0000);
  endtask

  task automatic run_wait(input logic [31:0] ctrl);
    int n;
    n = 0;
    apb(1'b1, pcrc_pkg::OFF_CTRL1, ctrl | 32'h10);
    do begin
      apb(1'b0, pcrc_pkg::OFF_CTRL1, 32'h0);
      n++;
    end while (rd[4] !== 1'b0 && n < 100);
    check(32'(rd[4]), 32'h0);
  endtask

  function automatic logic [31:0] crc_of(input logic [31:0] c, input logic [31:0] taps, input int poly_length,
                                         input int dw, input logic lsb, input int n);
    logic fb;
    for (int w = 0; w < n; w++) begin
      for (int i = 0; i <= dw; i++) begin
        fb = c[poly_length] ^ (lsb ? words[w][i] : words[w][dw - i]);
        c = c << 1;
        if (fb) begin
          c = c ^ taps;
        end
        c = c & (32'hffff_ffff >> (31 - poly_length));
      end
    end
    return c;
  endfunction

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, pcrc_pkg::OFF_CTRL1, 32'h0);
    check(rd, 32'h0000_0040);
    apb(1'b0, pcrc_pkg::OFF_CTRL2, 32'h0);
    check(rd, {16'h0000, pcrc_pkg::RST_CTRL2});
    apb(1'b1, 8'h30, 32'h0000_ffff);
    apb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    check(32'(slv_err), 32'h0);
    @(posedge clk_in);
    check(32'(pready_out), 32'h0);
    $display("test reset done");
    apb(1'b1, pcrc_pkg::OFF_IRQ_MASK, 32'h3);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h8000);
      apb(1'b1, pcrc_pkg::OFF_CTRL2, (k == 1) ? 32'h0f07 : 32'h0f06);
      repeat (17) push(16'h00a5);
      apb(1'b0, pcrc_pkg::OFF_CTRL1, 32'h0);
      check(rd & 32'h1fc0, (k == 1) ? 32'h0880 : 32'h1080);
      apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h0);
      apb(1'b0, pcrc_pkg::OFF_CTRL1, 32'h0);
      check(rd & 32'h1fc0, 32'h0040);
    end
    $display("test fifo done");
    words = '{16'h0031, 16'h0032, 16'h0033, 16'h0034};
    apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h8020);
    apb(1'b1, pcrc_pkg::OFF_CTRL2, 32'h070f);
    apb(1'b1, pcrc_pkg::OFF_TAPS_LO, 32'h1021);
    apb(1'b1, pcrc_pkg::OFF_TAPS_HI, 32'h0);
    apb(1'b0, pcrc_pkg::OFF_TAPS_LO, 32'h0);
    check(rd, 32'h0000_1021);
    apb(1'b1, pcrc_pkg::OFF_RES_LO, 32'h0);
    apb(1'b1, pcrc_pkg::OFF_RES_HI, 32'h0);
    for (int i = 0; i < 4; i++) push(words[i]);
    run_wait(32'h8020);
    exp_crc = crc_of(32'h0, 32'h1021, 15, 7, 1'b0, 4);
    apb(1'b0, pcrc_pkg::OFF_RES_LO, 32'h0);
    check(rd, {16'h0000, exp_crc[15:0]});
    apb(1'b0, pcrc_pkg::OFF_RES_HI, 32'h0);
    check(rd, {16'h0000, exp_crc[31:16]});
    apb(1'b0, pcrc_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h2);
    check(32'(irq_out), 32'h1);
    apb(1'b1, pcrc_pkg::OFF_IRQ_STAT, 32'h3);
    apb(1'b0, pcrc_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0);
    check(32'(irq_out), 32'h0);
    $display("test msb first done");
    words = '{16'h0abc, 16'h0123, 16'h0000, 16'h0000};
    apb(1'b1, pcrc_pkg::OFF_IRQ_MASK, 32'h2);
    apb(1'b1, pcrc_pkg::OFF_CTRL2, 32'h0b0f);
    push(words[0]);
    push(words[1]);
    run_wait(32'h8008);
    exp_crc = crc_of(exp_crc, 32'h1021, 15, 11, 1'b1, 2);
    apb(1'b0, pcrc_pkg::OFF_RES_LO, 32'h0);
    check(rd, {16'h0000, exp_crc[15:0]});
    apb(1'b1, pcrc_pkg::OFF_RES_LO, 32'h0);
    apb(1'b0, pcrc_pkg::OFF_RES_LO, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, pcrc_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd & 32'h3, 32'h1);
    check(32'(irq_out), 32'h0);
    apb(1'b1, pcrc_pkg::OFF_IRQ_MASK, 32'h3);
    apb(1'b0, pcrc_pkg::OFF_IRQ_MASK, 32'h0);
    check(32'(irq_out), 32'h1);
    apb(1'b1, pcrc_pkg::OFF_IRQ_STAT, 32'h3);
    $display("test lsb resume done");
    apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h8020);
    apb(1'b1, pcrc_pkg::OFF_CTRL2, 32'h070f);
    repeat (8) push(16'h005a);
    apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h8030);
    apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h8020);
    repeat (100) @(posedge clk_in);
    apb(1'b0, pcrc_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
    check(32'(irq_out), 32'h0);
    apb(1'b1, pcrc_pkg::OFF_CTRL1, 32'h0);
    $display("test manual stop done");
    give_verdict();
  end
endmodule
